// ===== counter_timer_pkg.sv
package counter_timer_pkg;

   // apb byte addresses
   localparam logic [7:0] ADDR_CHAN_WRITE = 8'h00;
   localparam logic [7:0] ADDR_CHAN_STATUS = 8'h04;
   localparam logic [7:0] ADDR_CHAN_SETTINGS = 8'h08;
   localparam logic [7:0] ADDR_INT_STATUS = 8'h0c;
   localparam logic [7:0] ADDR_INT_MASK = 8'h10;
   localparam logic [7:0] ADDR_INT_ACK = 8'h14;

   // channel control word bits
   localparam int CW_IE = 7;
   localparam int CW_COUNTER_MODE = 6;
   localparam int CW_PRESCALE_256 = 5;
   localparam int CW_RISING_EDGE = 4;
   localparam int CW_EXT_TRIGGER = 3;
   localparam int CW_TC_FOLLOWS = 2;
   localparam int CW_SW_RESET = 1;
   localparam int CW_CONTROL = 0;

   // vector word layout
   localparam int VEC_HI = 7;
   localparam int VEC_LO = 3;

   // prescaler terminal counts (divide by 16 or 256)
   localparam logic [7:0] PRESCALE_16_LAST = 8'h0f;
   localparam logic [7:0] PRESCALE_256_LAST = 8'hff;

   // status register fields
   localparam int ST_COUNT_LO = 0;
   localparam int ST_COUNT_HI = 8;
   localparam int ST_TC_PENDING = 9;
   localparam int ST_STATE_LO = 10;
   localparam int ST_STATE_HI = 11;

   // settings register fields
   localparam int SET_CTRL_LO = 0;
   localparam int SET_TC_LO = 8;
   localparam int SET_VEC_LO = 16;

   // interrupt status bits
   localparam int INT_REQUEST = 0;
   localparam int INT_ZERO = 1;
   localparam int INT_BITS = 2;

   // state codes as seen by software
   localparam logic [1:0] CODE_IDLE = 2'h0;
   localparam logic [1:0] CODE_WAIT_TRIG = 2'h1;
   localparam logic [1:0] CODE_RUN = 2'h2;

   // reset values
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [7:0] TC_RESET = 8'h00;
   localparam logic [7:0] VEC_RESET = 8'h00;
   localparam logic [8:0] COUNT_ONE = 9'h001;

   typedef enum logic [1:0] {
      st_idle,
      st_wait_trig,
      st_run
   } chan_state_type;

endpackage : counter_timer_pkg

// ===== trigger_edge_sync.sv
`timescale 1ns/1ps
`default_nettype none

module trigger_edge_sync (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // raw pin
   input wire logic pin_in,
   // edge pulses, one cycle each
   output logic rise_pulse,
   output logic fall_pulse
);

   logic meta_reg;
   logic sync_reg;
   logic last_reg;

   // meta_reg is read only by sync_reg
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_reg <= 1'b0;
         sync_reg <= 1'b0;
         last_reg <= 1'b0;
      end else begin
         meta_reg <= pin_in;
         sync_reg <= meta_reg;
         last_reg <= sync_reg;
      end
   end

   assign rise_pulse = sync_reg & ~last_reg;
   assign fall_pulse = ~sync_reg & last_reg;

endmodule : trigger_edge_sync

`default_nettype wire

// ===== counter_timer_block.sv
`timescale 1ns/1ps
`default_nettype none

module counter_timer_block #(
   parameter logic [1:0] CHANNEL_ID = 2'h0
) (
   // apb clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // pin
   input wire logic count_trigger_input,
   // interrupt
   output logic irq
);

   logic pready_reg;
   logic pslverr_reg;
   logic [31:0] prdata_reg;
   logic irq_reg;

   logic [7:0] control_reg;
   logic [7:0] tc_reg;
   logic [7:0] vector_reg;
   logic tc_pending_reg;

   counter_timer_pkg::chan_state_type state_reg;
   logic [8:0] count_reg;
   logic [7:0] prescale_reg;

   logic [counter_timer_pkg::INT_BITS-1:0] int_status_reg;
   logic [counter_timer_pkg::INT_BITS-1:0] int_mask_reg;
   logic [counter_timer_pkg::INT_BITS-1:0] int_status_next;

   logic rise_pulse;
   logic fall_pulse;
   logic active_edge;
   logic access;
   logic wr_en;
   logic rd_en;
   logic byte_wr;
   logic take_tc;
   logic take_ctrl;
   logic take_vec;
   logic [7:0] wbyte;
   logic [8:0] load_value;
   logic [7:0] prescale_last;
   logic prescale_tick;
   logic count_tick;
   logic zero_now;
   logic start_now;
   logic ack_read;
   logic mapped;
   logic [1:0] state_code;
   logic [31:0] rdata_mux;
   logic [counter_timer_pkg::INT_BITS-1:0] int_set;
   logic [counter_timer_pkg::INT_BITS-1:0] int_clr;

   trigger_edge_sync u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .pin_in(count_trigger_input),
      .rise_pulse(rise_pulse),
      .fall_pulse(fall_pulse)
   );

   // active edge of the pin
   assign active_edge = control_reg[counter_timer_pkg::CW_RISING_EDGE] ?
                        rise_pulse : fall_pulse;

   // apb decode; effects land at the edge where pready is seen high
   assign access = psel & penable;
   assign wr_en = access & pready_reg & pwrite;
   assign rd_en = access & pready_reg & ~pwrite;
   assign wbyte = pwdata[7:0];
   assign byte_wr = wr_en && (paddr == counter_timer_pkg::ADDR_CHAN_WRITE);

   // byte dispatch: a pending time constant takes any byte value
   assign take_tc = byte_wr & tc_pending_reg;
   assign take_ctrl = byte_wr & ~tc_pending_reg &
                      wbyte[counter_timer_pkg::CW_CONTROL];
   assign take_vec = byte_wr & ~tc_pending_reg &
                     ~wbyte[counter_timer_pkg::CW_CONTROL];

   assign ack_read = rd_en && (paddr == counter_timer_pkg::ADDR_INT_ACK);

   // zero written means a full 256 count
   assign load_value = {(tc_reg == 8'h00), tc_reg};

   // prescaler
   assign prescale_last = control_reg[counter_timer_pkg::CW_PRESCALE_256] ?
                          counter_timer_pkg::PRESCALE_256_LAST :
                          counter_timer_pkg::PRESCALE_16_LAST;
   assign prescale_tick = (prescale_reg == prescale_last);

   assign count_tick = control_reg[counter_timer_pkg::CW_COUNTER_MODE] ?
                       active_edge : prescale_tick;

   assign zero_now = (state_reg == counter_timer_pkg::st_run) && count_tick &&
                     (count_reg == counter_timer_pkg::COUNT_ONE);

   // a fresh time constant restarts only a stopped channel
   assign start_now = take_tc && (state_reg == counter_timer_pkg::st_idle);

   // control, time constant and vector storage
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         control_reg <= counter_timer_pkg::CTRL_RESET;
      end else if (take_ctrl) begin
         // ie may flip at any time, count keeps running
         control_reg <= wbyte;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tc_reg <= counter_timer_pkg::TC_RESET;
      end else if (take_tc) begin
         // a constant written while running only changes the reload
         tc_reg <= wbyte;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         vector_reg <= counter_timer_pkg::VEC_RESET;
      end else if (take_vec) begin
         vector_reg <= wbyte;
      end
   end

   // the byte after a control word with bit 2 set is the constant
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tc_pending_reg <= 1'b0;
      end else if (take_ctrl) begin
         tc_pending_reg <= wbyte[counter_timer_pkg::CW_TC_FOLLOWS];
      end else if (take_tc) begin
         tc_pending_reg <= 1'b0;
      end
   end

   // channel state and down-counter
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= counter_timer_pkg::st_idle;
         count_reg <= counter_timer_pkg::COUNT_ONE;
      end else if (take_ctrl && wbyte[counter_timer_pkg::CW_SW_RESET]) begin
         state_reg <= counter_timer_pkg::st_idle;
      end else begin
         case (state_reg)
            counter_timer_pkg::st_idle: begin
               // nothing counts before a time constant arrives
               if (start_now) begin
                  count_reg <= {(wbyte == 8'h00), wbyte};
                  if (!control_reg[counter_timer_pkg::CW_COUNTER_MODE] &&
                      control_reg[counter_timer_pkg::CW_EXT_TRIGGER]) begin
                     state_reg <= counter_timer_pkg::st_wait_trig;
                  end else begin
                     state_reg <= counter_timer_pkg::st_run;
                  end
               end
            end
            counter_timer_pkg::st_wait_trig: begin
               if (active_edge) begin
                  state_reg <= counter_timer_pkg::st_run;
               end
            end
            counter_timer_pkg::st_run: begin
               if (zero_now) begin
                  // reload picks up a constant rewritten while running
                  count_reg <= load_value;
               end else if (count_tick) begin
                  count_reg <= count_reg - counter_timer_pkg::COUNT_ONE;
               end
            end
            default: begin
               state_reg <= counter_timer_pkg::st_idle;
            end
         endcase
      end
   end

   // prescaler runs only while timing, restarts on every start
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prescale_reg <= 8'h00;
      end else if (state_reg != counter_timer_pkg::st_run ||
                   control_reg[counter_timer_pkg::CW_COUNTER_MODE]) begin
         prescale_reg <= 8'h00;
      end else if (prescale_tick) begin
         prescale_reg <= 8'h00;
      end else begin
         prescale_reg <= prescale_reg + 8'h01;
      end
   end

   // interrupt events; a set in the clearing cycle wins
   always_comb begin
      int_set = '0;
      int_clr = '0;
      int_set[counter_timer_pkg::INT_ZERO] = zero_now;
      int_set[counter_timer_pkg::INT_REQUEST] =
         zero_now & control_reg[counter_timer_pkg::CW_IE];
      if (wr_en && paddr == counter_timer_pkg::ADDR_INT_STATUS) begin
         int_clr = pwdata[counter_timer_pkg::INT_BITS-1:0];
      end
      // acknowledging the channel retires its request
      if (ack_read) begin
         int_clr[counter_timer_pkg::INT_REQUEST] = 1'b1;
      end
      int_status_next = (int_status_reg & ~int_clr) | int_set;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         int_status_reg <= '0;
      end else begin
         int_status_reg <= int_status_next;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         int_mask_reg <= '0;
      end else if (wr_en && paddr == counter_timer_pkg::ADDR_INT_MASK) begin
         int_mask_reg <= pwdata[counter_timer_pkg::INT_BITS-1:0];
      end
   end

   // registered from the next status, so it moves at the same edge as the status bit, glitch free
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_reg <= 1'b0;
      end else begin
         irq_reg <= |(int_status_next & int_mask_reg);
      end
   end

   // read path
   always_comb begin
      case (state_reg)
         counter_timer_pkg::st_wait_trig: state_code =
            counter_timer_pkg::CODE_WAIT_TRIG;
         counter_timer_pkg::st_run: state_code = counter_timer_pkg::CODE_RUN;
         default: state_code = counter_timer_pkg::CODE_IDLE;
      endcase
   end

   always_comb begin
      rdata_mux = 32'h0000_0000;
      mapped = 1'b1;
      case (paddr)
         counter_timer_pkg::ADDR_CHAN_WRITE: begin
            rdata_mux = 32'h0000_0000;
         end
         counter_timer_pkg::ADDR_CHAN_STATUS: begin
            rdata_mux[counter_timer_pkg::ST_COUNT_HI:
                      counter_timer_pkg::ST_COUNT_LO] = count_reg;
            rdata_mux[counter_timer_pkg::ST_TC_PENDING] = tc_pending_reg;
            rdata_mux[counter_timer_pkg::ST_STATE_HI:
                      counter_timer_pkg::ST_STATE_LO] = state_code;
         end
         counter_timer_pkg::ADDR_CHAN_SETTINGS: begin
            rdata_mux[counter_timer_pkg::SET_CTRL_LO +: 8] = control_reg;
            rdata_mux[counter_timer_pkg::SET_TC_LO +: 8] = tc_reg;
            rdata_mux[counter_timer_pkg::SET_VEC_LO +: 8] = vector_reg;
         end
         counter_timer_pkg::ADDR_INT_STATUS: begin
            rdata_mux[counter_timer_pkg::INT_BITS-1:0] = int_status_reg;
         end
         counter_timer_pkg::ADDR_INT_MASK: begin
            rdata_mux[counter_timer_pkg::INT_BITS-1:0] = int_mask_reg;
         end
         counter_timer_pkg::ADDR_INT_ACK: begin
            // channel identity fills bits 2..1, bit 0 stays clear
            rdata_mux[7:0] = {vector_reg[counter_timer_pkg::VEC_HI:
                                         counter_timer_pkg::VEC_LO],
                              CHANNEL_ID, 1'b0};
         end
         default: begin
            mapped = 1'b0;
         end
      endcase
   end

   // apb answer: one wait state, pready high in the second access cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_reg <= 1'b0;
      end else begin
         pready_reg <= access & ~pready_reg;
      end
   end

   // an unmapped address is refused together with pready
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pslverr_reg <= 1'b0;
      end else begin
         pslverr_reg <= access & ~pready_reg & ~mapped;
      end
   end

   // captured in the wait cycle, a write leaves zero behind
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_reg <= 32'h0000_0000;
      end else if (access && !pready_reg) begin
         prdata_reg <= pwrite ? 32'h0000_0000 : rdata_mux;
      end
   end

   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;
   assign irq = irq_reg;

endmodule : counter_timer_block

`default_nettype wire

// ===== trigger_pin_model.sv
`timescale 1ns/1ps
`default_nettype none

module trigger_pin_model (
   // clock
   input wire logic pclk,
   // requested level from the bench
   input wire logic level,
   // pin toward the block
   output logic pin
);
   // the pin is registered on the rising edge, so it only ever moves just after an edge
   always_ff @(posedge pclk) begin
      pin <= level;
   end
endmodule : trigger_pin_model

`default_nettype wire

// ===== counter_timer_block_assertions.sv
`timescale 1ns/1ps
`default_nettype none

module counter_timer_checker #(
   parameter logic [1:0] CHANNEL_ID = 2'h0
) (
   // apb
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // pin and interrupt
   input wire logic count_trigger_input,
   input wire logic irq
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   wire logic done_rd = pready && !pwrite;
   wire logic mapped = paddr <= counter_timer_pkg::ADDR_INT_ACK
      && paddr[1:0] == 2'h0;
   // any access that may lower a pending interrupt
   wire logic int_clr = pready && (pwrite
      ? paddr inside {counter_timer_pkg::ADDR_INT_STATUS,
                      counter_timer_pkg::ADDR_INT_MASK}
      : paddr == counter_timer_pkg::ADDR_INT_ACK);

   sequence setup_s;
      psel && !penable;
   endsequence
   sequence access_s;
      psel && penable;
   endsequence

   chk_one_wait: assert property (setup_s ##1 access_s |-> !pready ##1 pready)
      else $error("ready not in second access cycle");
   chk_ready_pulse: assert property (pready |=> !pready)
      else $error("ready longer than one cycle");
   chk_ready_sel: assert property (pready |-> access_s)
      else $error("ready outside an access");
   chk_err_unmapped: assert property (pready && !mapped |-> pslverr)
      else $error("unmapped access not refused");
   chk_err_mapped: assert property (pready && mapped |-> !pslverr)
      else $error("mapped access refused");
   chk_port_reads0: assert property (done_rd
      && paddr == counter_timer_pkg::ADDR_CHAN_WRITE |-> prdata == 32'h0)
      else $error("write port read not zero");
   chk_ack_id: assert property (done_rd && paddr ==
      counter_timer_pkg::ADDR_INT_ACK |-> prdata[2:0] == {CHANNEL_ID, 1'b0})
      else $error("acknowledge vector lacks channel id");
   chk_irq_fall: assert property ($fell(irq) |->
      $past(int_clr) || $past(int_clr, 2))
      else $error("interrupt dropped without clear");
endmodule : counter_timer_checker

bind counter_timer_block counter_timer_checker #(.CHANNEL_ID(CHANNEL_ID)) u_chk (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr),
   .count_trigger_input(count_trigger_input), .irq(irq));

`default_nettype wire

// ===== test_counter_timer_block.sv
`timescale 1ns/1ps
`default_nettype none

module test_counter_timer_block;
   localparam logic [7:0] A_WR = counter_timer_pkg::ADDR_CHAN_WRITE;
   localparam logic [7:0] A_ST = counter_timer_pkg::ADDR_CHAN_STATUS;
   localparam logic [7:0] A_SET = counter_timer_pkg::ADDR_CHAN_SETTINGS;
   localparam logic [7:0] A_IS = counter_timer_pkg::ADDR_INT_STATUS;
   localparam logic [7:0] A_IM = counter_timer_pkg::ADDR_INT_MASK;
   localparam logic [7:0] A_ACK = counter_timer_pkg::ADDR_INT_ACK;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic want_level = 1'b0;
   wire logic [31:0] prdata;
   wire logic pready;
   wire logic pslverr;
   wire logic pin;
   wire logic irq;
   logic [31:0] rd;
   logic err;
   int n_mismatch = 0;
   int num_checks = 0;

   always #50 pclk = ~pclk;

   counter_timer_block #(.CHANNEL_ID(2'h2)) u_dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .count_trigger_input(pin),
      .irq(irq));
   trigger_pin_model u_pin (.pclk(pclk), .level(want_level), .pin(pin));

   task results;
      if (n_mismatch == 0 && num_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : results

   task cmp(input logic [31:0] got, input logic [31:0] exp, input string m);
      num_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: %s", $time, m);
      end
   endtask : cmp

   // entered just after a rising edge, leaves just after one
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         n_mismatch++;
         results();
      end else begin
         rd = prdata;
         err = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
         @(posedge pclk);
      end
   endtask : apb

   task wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask : wr

   task rdx(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
            input string s);
      apb(1'b0, a, 32'h0);
      cmp(rd & m, e, s);
   endtask : rdx

   // edge needs sync plus detect before the count moves
   task pin_to(input logic v);
      want_level <= v;
      repeat (6) @(posedge pclk);
   endtask : pin_to

   initial begin
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rdx(A_SET, 32'hffffff, 32'h0, "settings after reset");
      rdx(A_ST, 32'he00, 32'h0, "idle after reset");
      apb(1'b0, 8'h40, 32'h0);
      cmp({31'h0, err}, 32'h1, "unmapped not refused");
      rdx(A_WR, 32'hffffffff, 32'h0, "write port read");
      wr(A_IM, 32'h3);
      wr(A_WR, 32'hc5);
      rdx(A_ST, 32'h200, 32'h200, "time constant not pending");
      wr(A_WR, 32'h3);
      rdx(A_ST, 32'hfff, 32'h803, "count 3 running");
      pin_to(1'b1);
      rdx(A_ST, 32'h1ff, 32'h3, "counted inactive edge");
      pin_to(1'b0);
      rdx(A_ST, 32'h1ff, 32'h2, "missed pin edge");
      wr(A_WR, 32'h41);
      rdx(A_ST, 32'hfff, 32'h802, "enable change upset count");
      wr(A_WR, 32'hc1);
      repeat (2) begin
         pin_to(1'b1);
         pin_to(1'b0);
      end
      rdx(A_ST, 32'h1ff, 32'h3, "no reload at zero");
      rdx(A_IS, 32'h3, 32'h3, "zero event flags");
      cmp({31'h0, irq}, 32'h1, "interrupt low");
      wr(A_WR, 32'hf8);
      rdx(A_SET, 32'hff0000, 32'hf80000, "vector not stored");
      rdx(A_ACK, 32'hff, 32'hfc, "acknowledge vector");
      rdx(A_IS, 32'h3, 32'h2, "acknowledge did not clear request");
      wr(A_IS, 32'h3);
      repeat (2) @(posedge pclk);
      cmp({31'h0, irq}, 32'h0, "interrupt stuck");
      wr(A_WR, 32'h3);
      rdx(A_ST, 32'hc00, 32'h0, "software reset kept running");
      wr(A_WR, 32'h47);
      wr(A_WR, 32'h0);
      rdx(A_ST, 32'hfff, 32'h900, "zero not 256");
      wr(A_WR, 32'h1f);
      wr(A_WR, 32'h2);
      rdx(A_ST, 32'hc00, 32'h400, "no wait for trigger");
      wr(A_IS, 32'h3);
      pin_to(1'b1);
      repeat (10) @(posedge pclk);
      rdx(A_IS, 32'h2, 32'h0, "divide by 16 too fast");
      repeat (30) @(posedge pclk);
      rdx(A_IS, 32'h3, 32'h2, "divide by 16 too slow");
      wr(A_WR, 32'h27);
      wr(A_IS, 32'h3);
      wr(A_WR, 32'h1);
      repeat (200) @(posedge pclk);
      rdx(A_IS, 32'h2, 32'h0, "divide by 256 too fast");
      repeat (80) @(posedge pclk);
      rdx(A_IS, 32'h2, 32'h2, "divide by 256 too slow");
      results();
   end
endmodule : test_counter_timer_block

`default_nettype wire
